// ===== design/dwc_regs.vh
// Constants for the watchpoint control register block.
// Notes on behaviour
// (R1) Mask field sets how many low address bits are ignored, 3 to 31; zero none.
// (R2) Mask encodings 1 and 2 act as no mask; reads return the written value.
// (R3) Type bit: zero unlinked data address match, one linked match.
// (R4) Linked breakpoint index used only when linked; otherwise ignored.
// (R5) Event qualification combines security, higher mode, privilege and extended security bits.
// (R6) Extended security bit exists only with the realm feature; otherwise reads zero.
// (R7) Byte-select bit k watches byte k of the watched word or doubleword; with a mask of 3 or more the code ignores it and watches all eight bytes.
// (R8) Watched address bit 2 set: only low four byte-select bits are used.
// (R9) Software programs byte-select only with non-zero contiguous runs.
// (R10) Load/store field matches loads 01, stores 10, both 11.
// (R11) Load/store encoding 00 makes the watchpoint behave as disabled.
// (R12) Enable bit clear means the watchpoint never raises an event.
// (R13) Control fields hold no defined value after cold reset.
// (R14) Register m selected by op0 10, op1 000, CRn 0000, CRm m, op2 111.
// (R15) Index beyond implemented count, or lowest privilege level, is undefined.
// (R16) Kernel level, hypervisor on, fine-grain trap allowed and set: trap to hypervisor, class 0x18.
// (R17) Kernel level, hypervisor on, routing or access trap bit set: trap to hypervisor.
// (R18) Top-level access trap: undefined if halted with secure debug off, else trap to top.
// (R19) Otherwise, OS lock clear, halting allowed, external trap set: enter debug halt.
// (R20) Otherwise a read returns the register and a write stores it.
`ifndef DWC_REGS_VH
`define DWC_REGS_VH
`define DWC_OP0 2'h2
`define DWC_OP1 3'h0
`define DWC_CRN 4'h0
`define DWC_OP2 3'h7
`define DWC_EC_TRAP 6'h18
`define DWC_EL0 2'h0
`define DWC_EL1 2'h1
`define DWC_EL2 2'h2
`define DWC_EL3 2'h3
`define DWC_SECURITY_STATE_QUALIFIER_EXT_BIT 29
`define DWC_MASK_HI 28
`define DWC_MASK_LO 24
`define DWC_WT_BIT 20
`define DWC_LBN_HI 19
`define DWC_LBN_LO 16
`define DWC_SSC_HI 15
`define DWC_SSC_LO 14
`define DWC_HMC_BIT 13
`define DWC_BAS_HI 12
`define DWC_BAS_LO 5
`define DWC_LSC_HI 4
`define DWC_LSC_LO 3
`define DWC_PAC_HI 2
`define DWC_PAC_LO 1
`define DWC_E_BIT 0
`define DWC_MASK_MIN 5'h03
`define DWC_LSC_LOAD 2'h1
`define DWC_LSC_STORE 2'h2
`define DWC_WMASK_BASE 64'h0000_0000_1f1f_ffff
`define DWC_CNT_W 5
`define DWC_ACC_OK 3'h0
`define DWC_ACC_UNDEF 3'h1
`define DWC_ACC_TRAP2 3'h2
`define DWC_ACC_TRAP3 3'h3
`define DWC_ACC_HALT 3'h4
`endif

// ===== design/dwc_watch_ctrl.v
// Watchpoint control registers, their system access path and match qualification.
`timescale 1ns/1ns
`default_nettype none
`include "dwc_regs.vh"
module dwc_watch_ctrl #(
  parameter NUM_WATCH = 16,
  parameter HAVE_REALM = 0,
  parameter HAVE_FGT = 1,
  parameter HAVE_EL3 = 1,
  parameter EL3_SDD_PRIO = 0
) (
  // Clock and reset.
  input wire clock_i,
  input wire reset_n_i,
  // System instruction request.
  input wire acc_valid_i,
  input wire acc_write_i,
  input wire [1:0] acc_op0_i,
  input wire [2:0] acc_op1_i,
  input wire [3:0] acc_crn_i,
  input wire [3:0] acc_crm_i,
  input wire [2:0] acc_op2_i,
  input wire [63:0] acc_wdata_i,
  input wire [1:0] cur_el_i,
  // Debug configuration state from the rest of the core.
  input wire el2_enabled_i,
  input wire halted_i,
  input wire halting_allowed_i,
  input wire secure_debug_disabled_i,
  input wire debug_access_trap_ext_i,
  input wire os_lock_flag_i,
  input wire hyp_debug_access_trap_i,
  input wire debug_exception_route_i,
  input wire top_debug_access_trap_i,
  input wire fine_grain_trap_allow_i,
  input wire fine_grain_read_trap_i,
  input wire fine_grain_write_trap_i,
  // Data access to be checked against watchpoints.
  input wire mem_valid_i,
  input wire mem_load_i,
  input wire mem_store_i,
  input wire [63:0] mem_addr_i,
  input wire [7:0] mem_bytes_i,
  input wire [1:0] mem_el_i,
  input wire mem_secure_i,
  // Per-watchpoint address values from the companion registers.
  input wire [64*16-1:0] watch_address_value_i,
  // Access answer.
  output reg acc_done_o,
  output reg [2:0] acc_result_o,
  output reg [5:0] acc_ec_o,
  output reg [1:0] acc_target_el_o,
  output reg [63:0] acc_rdata_o,
  // Match answer.
  output reg [15:0] watch_hit_o,
  output reg [15:0] watch_linked_o
);

  reg [63:0] ctrl_q [0:15];
  reg [2:0] res_d;
  wire [63:0] wmask;
  wire sel;
  wire in_range;
  wire fg_trap;
  integer i;

  // Writable bits; the extended security bit only exists with the realm feature.
  assign wmask = `DWC_WMASK_BASE | (HAVE_REALM ? (64'h1 << `DWC_SECURITY_STATE_QUALIFIER_EXT_BIT) : 64'h0); // R6
  assign sel = (acc_op0_i == `DWC_OP0) && (acc_op1_i == `DWC_OP1) && (acc_crn_i == `DWC_CRN) &&
    (acc_op2_i == `DWC_OP2); // R14
  assign in_range = ({1'b0, acc_crm_i} < NUM_WATCH[`DWC_CNT_W-1:0]);
  assign fg_trap = acc_write_i ? fine_grain_write_trap_i : fine_grain_read_trap_i;

  // Access decision in priority order; the first check that fires decides.
  always @* begin
    res_d = `DWC_ACC_OK;
    if (!in_range || cur_el_i == `DWC_EL0) begin
      res_d = `DWC_ACC_UNDEF; // R15
    end else if (cur_el_i == `DWC_EL1 || cur_el_i == `DWC_EL2) begin
      if (halted_i && HAVE_EL3 != 0 && secure_debug_disabled_i && EL3_SDD_PRIO != 0 &&
          top_debug_access_trap_i) begin
        res_d = `DWC_ACC_UNDEF; // R18
      end else if (cur_el_i == `DWC_EL1 && el2_enabled_i && HAVE_FGT != 0 &&
          (HAVE_EL3 == 0 || fine_grain_trap_allow_i) && fg_trap) begin
        res_d = `DWC_ACC_TRAP2; // R16
      end else if (cur_el_i == `DWC_EL1 && el2_enabled_i &&
          (debug_exception_route_i || hyp_debug_access_trap_i)) begin
        res_d = `DWC_ACC_TRAP2; // R17
      end else if (HAVE_EL3 != 0 && top_debug_access_trap_i) begin
        res_d = (halted_i && secure_debug_disabled_i) ? `DWC_ACC_UNDEF : `DWC_ACC_TRAP3; // R18
      end else if (!os_lock_flag_i && halting_allowed_i && debug_access_trap_ext_i) begin
        res_d = `DWC_ACC_HALT; // R19
      end
    end else if (!os_lock_flag_i && halting_allowed_i && debug_access_trap_ext_i) begin
      res_d = `DWC_ACC_HALT; // R19
    end
  end

  // Register storage has no reset: contents stay undefined until written.
  always @(posedge clock_i) begin
    if (acc_valid_i && sel && acc_write_i && res_d == `DWC_ACC_OK) begin
      ctrl_q[acc_crm_i] <= acc_wdata_i & wmask; // R13 R20
    end
  end

  // Answer registers; one-cycle done pulse per selected access.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      acc_done_o <= 1'b0;
      acc_result_o <= `DWC_ACC_OK;
      acc_ec_o <= 6'h00;
      acc_target_el_o <= `DWC_EL0;
      acc_rdata_o <= 64'h0;
    end else begin
      acc_done_o <= acc_valid_i && sel;
      if (acc_valid_i && sel) begin
        acc_result_o <= res_d;
        acc_ec_o <= (res_d == `DWC_ACC_TRAP2 || res_d == `DWC_ACC_TRAP3) ? `DWC_EC_TRAP : 6'h00; // R16
        acc_target_el_o <= (res_d == `DWC_ACC_TRAP2) ? `DWC_EL2 :
          (res_d == `DWC_ACC_TRAP3) ? `DWC_EL3 : cur_el_i;
        // Reads return stored value; the mask field reads back as written even if reserved.
        acc_rdata_o <= (!acc_write_i && res_d == `DWC_ACC_OK) ? ctrl_q[acc_crm_i] : 64'h0; // R2 R20
      end
    end
  end

  // Match logic per watchpoint, registered so outputs come from flip-flops.
  reg [4:0] mk;
  reg [63:0] amask;
  reg [63:0] wa;
  reg [63:0] c;
  reg [7:0] byte_lane_select;
  reg [7:0] lanes;
  reg lsc_ok;
  reg priv_ok;
  reg sec_ok;
  reg [15:0] hit_d;
  reg [15:0] link_d;
  always @* begin
    hit_d = 16'h0;
    link_d = 16'h0;
    mk = 5'h0;
    amask = 64'h0;
    wa = 64'h0;
    c = 64'h0;
    byte_lane_select = 8'h0;
    lanes = 8'h0;
    lsc_ok = 1'b0;
    priv_ok = 1'b0;
    sec_ok = 1'b0;
    for (i = 0; i < 16; i = i + 1) begin
      c = ctrl_q[i];
      wa = watch_address_value_i[i*64 +: 64];
      mk = c[`DWC_MASK_HI:`DWC_MASK_LO];
      // Reserved mask encodings fall back to no mask, the cheapest legal choice.
      amask = (mk < `DWC_MASK_MIN) ? 64'h0 : ((64'h1 << mk) - 64'h1); // R1 R2
      byte_lane_select = c[`DWC_BAS_HI:`DWC_BAS_LO]; // R7
      if (wa[2]) begin
        byte_lane_select = {4'h0, byte_lane_select[3:0]}; // R8
      end
      // Lanes relative to doubleword; a word-aligned value watches the upper half.
      lanes = (mk >= `DWC_MASK_MIN) ? 8'hff : (wa[2] ? {byte_lane_select[3:0], 4'h0} : byte_lane_select);
      lsc_ok = (c[`DWC_LSC_LO] && mem_load_i) || (c[`DWC_LSC_HI] && mem_store_i); // R10 R11
      // Privilege bits: bit1 matches the kernel level, bit2 the lowest; higher mode adds levels 2 and 3.
      priv_ok = (mem_el_i == `DWC_EL0 && c[`DWC_PAC_HI]) || (mem_el_i == `DWC_EL1 && c[`DWC_PAC_LO]) ||
        (mem_el_i[1] && c[`DWC_HMC_BIT]); // R5
      sec_ok = (c[`DWC_SSC_HI:`DWC_SSC_LO] == 2'h0) || (c[`DWC_SSC_HI] && !mem_secure_i) ||
        (c[`DWC_SSC_LO] && mem_secure_i) || (HAVE_REALM != 0 && c[`DWC_SECURITY_STATE_QUALIFIER_EXT_BIT]); // R5 R6
      if (i < NUM_WATCH && c[`DWC_E_BIT] && mem_valid_i && lsc_ok && priv_ok && sec_ok && // R12
          (((mem_addr_i ^ wa) & ~amask & ~64'h7) == 64'h0) && ((lanes & mem_bytes_i) != 8'h0)) begin
        if (c[`DWC_WT_BIT]) begin
          link_d[i] = 1'b1; // R3 R4
        end else begin
          hit_d[i] = 1'b1; // R3
        end
      end
    end
  end

  // Linked hits are handed to the breakpoint side; it checks the index itself.
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      watch_hit_o <= 16'h0;
      watch_linked_o <= 16'h0;
    end else begin
      watch_hit_o <= hit_d;
      watch_linked_o <= link_d;
    end
  end

endmodule
`default_nettype wire

// ===== verif/dwc_watch_ctrl_properties.sv
// Port checks for the watchpoint control block.
`timescale 1ns/1ns
`default_nettype none
module dwc_watch_ctrl_chk (
  // Clock, reset and request.
  input wire clock_i,
  input wire reset_n_i,
  input wire acc_valid_i,
  input wire [1:0] acc_op0_i,
  input wire [2:0] acc_op1_i,
  input wire [3:0] acc_crn_i,
  input wire [2:0] acc_op2_i,
  input wire [1:0] cur_el_i,
  input wire mem_valid_i,
  // Answers.
  input wire acc_done_o,
  input wire [2:0] acc_result_o,
  input wire [5:0] acc_ec_o,
  input wire [63:0] acc_rdata_o,
  input wire [15:0] watch_hit_o
);
  // Only the control register encoding counts as a request.
  wire sel = acc_valid_i && {acc_op0_i, acc_op1_i, acc_crn_i, acc_op2_i} == 12'h807;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_sel; sel; endsequence
  sequence s_el0; sel && cur_el_i == 2'h0; endsequence
  property p_done; s_sel |=> acc_done_o; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_idle; !sel |=> !acc_done_o; endproperty
  a_idle: assert property (p_idle) else $error("stray done");
  property p_el0; s_el0 |=> acc_result_o == 3'h1; endproperty
  a_el0: assert property (p_el0) else $error("low level allowed");
  property p_trap; acc_done_o && acc_result_o[2:1] == 2'h1 |-> acc_ec_o == 6'h18; endproperty
  a_trap: assert property (p_trap) else $error("bad trap class");
  property p_okec; acc_done_o && acc_result_o == 3'h0 |-> acc_ec_o == 6'h0; endproperty
  a_okec: assert property (p_okec) else $error("class on success");
  property p_rdz; acc_done_o && acc_result_o != 3'h0 |-> acc_rdata_o == 64'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("data on refusal");
  property p_hold; !sel |=> $stable(acc_result_o) && $stable(acc_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("answer moved");
  property p_hit; !mem_valid_i |=> watch_hit_o == 16'h0; endproperty
  a_hit: assert property (p_hit) else $error("hit without access");
endmodule
bind dwc_watch_ctrl dwc_watch_ctrl_chk u_chk (.*);
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the watchpoint control block.
`timescale 1ns/1ns
`default_nettype none
module tb;
  // Rows of lsc, enable, load, expected hit.
  localparam [34:0] MT = {5'h0f, 5'h0c, 5'h15, 5'h1f, 5'h06, 5'h1a, 5'h1d};
  logic clock_i = 0, reset_n_i = 0, acc_valid_i = 0, acc_write_i = 0;
  logic mem_valid_i = 0, mem_load_i = 0, mem_store_i = 0, mem_secure_i = 0;
  logic [1:0] acc_op0_i = 2'h2, cur_el_i = 2'h1, mem_el_i = 2'h1;
  logic [2:0] acc_op1_i = 3'h0, acc_op2_i = 3'h7;
  logic [3:0] acc_crn_i = 4'h0, acc_crm_i = 4'h0;
  logic [63:0] acc_wdata_i = 64'h0, mem_addr_i = 64'h1000;
  logic [7:0] mem_bytes_i = 8'h01;
  logic [1023:0] watch_address_value_i = {16{64'h1000}};
  logic [11:0] cf = 12'h0;
  logic [63:0] mdl [16];
  int mismatches = 0, compares = 0, cyc = 0;
  wire el2_enabled_i, halted_i, halting_allowed_i, secure_debug_disabled_i, debug_access_trap_ext_i;
  wire os_lock_flag_i, hyp_debug_access_trap_i, debug_exception_route_i, top_debug_access_trap_i;
  wire fine_grain_trap_allow_i, fine_grain_read_trap_i, fine_grain_write_trap_i, acc_done_o;
  wire [2:0] acc_result_o;
  wire [5:0] acc_ec_o;
  wire [1:0] acc_target_el_o;
  wire [63:0] acc_rdata_o;
  wire [15:0] watch_hit_o, watch_linked_o;
  // One vector feeds every trap input so random draws reach them all.
  assign {el2_enabled_i, halted_i, halting_allowed_i, secure_debug_disabled_i, debug_access_trap_ext_i,
    os_lock_flag_i, hyp_debug_access_trap_i, debug_exception_route_i, top_debug_access_trap_i,
    fine_grain_trap_allow_i, fine_grain_read_trap_i, fine_grain_write_trap_i} = cf;
  dwc_watch_ctrl #(.NUM_WATCH(12)) dut (.*);
  // Expected answer, checked in priority order.
  function automatic [2:0] er(input [3:0] m, input [1:0] el, input w);
    if (m >= 4'd12 || el == 2'h0) return 3'h1;
    if (el == 2'h1 && cf[11] && cf[2] && (w ? cf[0] : cf[1])) return 3'h2;
    if (el == 2'h1 && cf[11] && (cf[5] || cf[4])) return 3'h2;
    if (el != 2'h3 && cf[3]) return (cf[10] && cf[8]) ? 3'h1 : 3'h3;
    return (!cf[6] && cf[9] && cf[7]) ? 3'h4 : 3'h0;
  endfunction
  task automatic chk(input string n, input logic [63:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // One access, held for a single edge, answer checked the cycle after.
  task automatic acc(input w, input [3:0] m, input [1:0] el, input [11:0] e, input [63:0] d);
    logic [2:0] r;
    @(posedge clock_i);
    {acc_valid_i, acc_write_i, acc_crm_i, cur_el_i, acc_op0_i, acc_op1_i, acc_crn_i, acc_op2_i, acc_wdata_i} <=
      {1'b1, w, m, el, e, d};
    @(posedge clock_i);
    acc_valid_i <= 1'b0;
    #1;
    r = er(m, el, w);
    chk("done", acc_done_o, e == 12'h807);
    if (e == 12'h807) begin
      chk("result", acc_result_o, r);
      chk("class", acc_ec_o, r[2:1] == 2'h1 ? 6'h18 : 6'h0);
      chk("target", acc_target_el_o, r[2:1] == 2'h1 ? r[1:0] : el);
      chk("rdata", acc_rdata_o, (r == 3'h0 && !w) ? mdl[m] : 64'h0);
      if (r == 3'h0 && w) mdl[m] = d & 64'h1f1f_ffff;
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial forever #4 clock_i = ~clock_i;
  // The run needs about nine hundred cycles, so this ceiling only catches a hang.
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test;
    end
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h249c62bd));
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int m = 0; m < 16; m++) acc(1'b1, 4'(m), 2'h1, 12'h807, {$urandom, $urandom});
    for (int m = 0; m < 16; m++) acc(1'b0, 4'(m), 2'h1, 12'h807, 64'h0);
    acc(1'b1, 4'h5, 2'h0, 12'h807, '1);
    acc(1'b1, 4'h5, 2'h1, 12'h805, '1);
    acc(1'b0, 4'h5, 2'h1, 12'h807, 64'h0);
    $display("test register access done");
    repeat (400) begin
      cf <= 12'($urandom);
      acc(1'($urandom), 4'($urandom), 2'($urandom), ($urandom % 8 == 0) ? 12'($urandom) : 12'h807,
        {$urandom, $urandom});
    end
    cf <= 12'h0;
    $display("test trap decisions done");
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, 4'h0, 2'h1, 12'h807, 64'h26 | {59'h0, MT[i*5+3 +: 2], 2'h0, MT[i*5+2]});
      @(posedge clock_i);
      {mem_valid_i, mem_load_i, mem_store_i} <= {1'b1, MT[i*5+1], !MT[i*5+1]};
      @(posedge clock_i);
      mem_valid_i <= 1'b0;
      #1;
      chk("hit", watch_hit_o[0], MT[i*5]);
      chk("linked", watch_linked_o[0], 1'b0);
    end
    // A linked watchpoint reports on the linked output only, and its index reads back.
    acc(1'b1, 4'h0, 2'h1, 12'h807, 64'h0013_003f);
    acc(1'b0, 4'h0, 2'h1, 12'h807, 64'h0);
    @(posedge clock_i);
    {mem_valid_i, mem_load_i, mem_store_i} <= 3'h6;
    @(posedge clock_i);
    mem_valid_i <= 1'b0;
    #1;
    chk("linked", watch_linked_o[0], 1'b1);
    chk("unlinked", watch_hit_o[0], 1'b0);
    $display("test match qualification done");
    end_of_test;
  end
endmodule
`default_nettype wire
